// ---- hw/haptic_tuning_regs.svh ----
// register indices, field positions, reset values and decode constants of the tuning and fault bank
`ifndef HAPTIC_TUNING_REGS_SVH
`define HAPTIC_TUNING_REGS_SVH

// ****************************************************************
// register indices (byte address on the bus is four times these)
// ****************************************************************
`define IDX_PHASE_DELAY_LOW 8'h49
`define IDX_FREQ_TRACK_CTL 8'h4c
`define IDX_LOCKOUT_TRIM 8'h5f
`define IDX_LOOP_FILTER_TRIM 8'h60
`define IDX_EDGE_RATE_TRIM 8'h62
`define IDX_TOP_CONFIG_FIVE 8'h6e
`define IDX_FAULT_EVENT 8'h81
`define IDX_INT_STATE_TWO 8'h82
`define IDX_INT_MASK_TWO 8'h83
`define IDX_SNIPPET_FIRST 8'h84
`define IDX_SNIPPET_LAST 8'he7
`define SNIPPET_BYTES 100

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_DELAY_FREEZE 7
`define BIT_TRACK_AUTOSCALE 1
`define BIT_TRACK_FORCE 0
`define BIT_IDAC_DOUBLE 6
`define BIT_FILT_LOW_BW 5
`define LSB_UVLO_LEVEL 3
`define LSB_FILT_CAP 2
`define LSB_LOW_SLEW 2
`define BIT_DELAY_BYPASS 2
`define BIT_HOLD_FREQ 1
`define BIT_V2I_OFFSET 0
`define BIT_SAT_FLAG 2
`define BIT_SAT_STATE 7
`define BIT_SAT_MASK 7

// ****************************************************************
// reset values
// ****************************************************************
`define RST_DELAY_SHIFT 3'h5
`define RST_TRACK_AUTOSCALE 1'h1
`define RST_UVLO_LEVEL 2'h1
`define RST_FILT_CAP 2'h3
`define RST_SLEW 2'h3
`define RST_V2I_OFFSET 1'h1

// ****************************************************************
// decode constants
// ****************************************************************
`define UVLO_BASE_DV 8'h1b
`define SLEW_STEP_MV_NS 8'h19
`define V2I_OFFSET_MV 8'h32

`endif

// ---- hw/haptic_tuning_pkg.sv ----
// types shared by the tuning and fault register bank
`default_nettype none

package haptic_tuning_pkg;

  typedef logic [7:0] byte_t;

  // ****************************************************************
  // complete state of the register bank
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic delay_freeze;
    logic [2:0] delay_shift;
    logic tracking_autoscale;
    logic tracking_force_enable;
    logic idac_double;
    logic filt_low_bw;
    logic [1:0] undervoltage_lockout_level;
    logic [1:0] filt_cap;
    logic [1:0] filt_res;
    logic [1:0] low_side_slew_setting;
    logic [1:0] high_side_slew_setting;
    logic delay_bypass;
    logic hold_frequency_on_reversal;
    logic voltage_current_offset_enable;
    logic converter_saturation_flag;
    logic converter_saturation_state;
    logic converter_saturation_mask;
    logic [99:0][7:0] snippet;
  } bank_state_t;

endpackage

`default_nettype wire

// ---- hw/tracking_force_guard.sv ----
// decides when frequency tracking is forced on by a large tracking error
`timescale 1ns/1ps
`default_nettype none

module tracking_force_guard (
  input wire logic force_enable,
  input wire logic [15:0] tracking_error,
  input wire logic [15:0] initial_guess,
  output logic force_tracking
);

  logic [17:0] error_x4;
  logic [17:0] guess_wide;

  // compare error*4 against the guess so a quarter needs no divider and loses no bits
  assign error_x4 = {tracking_error, 2'b00};
  assign guess_wide = {2'b00, initial_guess};
  assign force_tracking = force_enable && (error_x4 > guess_wide);

endmodule // tracking_force_guard

`default_nettype wire

// ---- hw/drive_setting_decode.sv ----
// turns stored codes into the values the drive engines consume
`timescale 1ns/1ps
`default_nettype none

`include "haptic_tuning_regs.svh"

module drive_setting_decode (
  input wire logic [1:0] lockout_code,
  input wire logic [1:0] low_slew_code,
  input wire logic [1:0] high_slew_code,
  input wire logic offset_enable,
  input wire logic hold_on_reversal,
  input wire logic rapid_stop_active,
  input wire logic negative_acceleration,
  input wire logic direct_override_negative,
  output logic [7:0] lockout_threshold_dv,
  output logic [7:0] low_side_rate_mv_ns,
  output logic [7:0] high_side_rate_mv_ns,
  output logic [7:0] v2i_offset_mv,
  output logic pause_frequency_update
);

  logic polarity_reversed;

  // thresholds in tenths of a volt: 2.7, 2.8, 2.9, 3.0
  assign lockout_threshold_dv = `UVLO_BASE_DV + {6'h00, lockout_code};
  // 25 mV/ns per code step, code 0 already gives one step
  assign low_side_rate_mv_ns = `SLEW_STEP_MV_NS * ({6'h00, low_slew_code} + 8'h01);
  assign high_side_rate_mv_ns = `SLEW_STEP_MV_NS * ({6'h00, high_slew_code} + 8'h01);
  assign v2i_offset_mv = offset_enable ? `V2I_OFFSET_MV : 8'h00;

  assign polarity_reversed = rapid_stop_active | negative_acceleration | direct_override_negative;
  assign pause_frequency_update = hold_on_reversal & polarity_reversed;

endmodule // drive_setting_decode

`default_nettype wire

// ---- hw/haptic_tuning_fault_register_bank.sv ----
// tuning, fault and snippet memory register bank on a classic wishbone slave
`timescale 1ns/1ps
`default_nettype none

`include "haptic_tuning_regs.svh"

module haptic_tuning_fault_register_bank (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clock_enable,
  // wishbone classic slave
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  // engine side inputs
  input wire logic converter_saturated,
  input wire logic [15:0] tracking_error,
  input wire logic [15:0] initial_guess,
  input wire logic rapid_stop_active,
  input wire logic negative_acceleration,
  input wire logic direct_override_negative,
  input wire logic [6:0] snippet_read_index,
  // engine side settings and data, and the interrupt request
  output haptic_tuning_pkg::byte_t snippet_read_data,
  output logic [2:0] phase_delay_shift,
  output logic phase_delay_freeze,
  output logic tracking_autoscale,
  output logic force_tracking,
  output logic loop_idac_double,
  output logic loop_filter_low_bw,
  output logic [1:0] loop_filter_cap,
  output logic [1:0] loop_filter_res,
  output logic delay_compare_bypass,
  output logic [7:0] lockout_threshold_dv,
  output logic [7:0] low_side_rate_mv_ns,
  output logic [7:0] high_side_rate_mv_ns,
  output logic [7:0] v2i_offset_mv,
  output logic pause_frequency_update,
  output logic irq
);

  import haptic_tuning_pkg::*;

  bank_state_t state_reg;
  bank_state_t state_next;

  logic request;
  logic [7:0] index;
  logic [7:0] snip_offset;
  logic [6:0] snip_slot;
  logic in_snippet;
  logic wr_low;
  logic [7:0] wbyte;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // a request is answered once; ack drops the cycle after it was given
  assign request = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign index = wb_adr_i[9:2];
  assign snip_offset = index - `IDX_SNIPPET_FIRST;
  assign snip_slot = snip_offset[6:0];
  assign in_snippet = (index >= `IDX_SNIPPET_FIRST) && (index <= `IDX_SNIPPET_LAST);
  // registers are one byte wide, so only lane 0 carries a write
  assign wr_low = request && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  function automatic logic [7:0] read_byte(input bank_state_t s, input logic [7:0] idx, input logic [6:0] slot,
                                           input logic snip);
    logic [7:0] v;
    v = 8'h00;
    if (snip) begin
      v = s.snippet[slot];
    end else if (idx == `IDX_PHASE_DELAY_LOW) begin
      v[`BIT_DELAY_FREEZE] = s.delay_freeze;
      v[2:0] = s.delay_shift;
    end else if (idx == `IDX_FREQ_TRACK_CTL) begin
      v[`BIT_TRACK_AUTOSCALE] = s.tracking_autoscale;
      v[`BIT_TRACK_FORCE] = s.tracking_force_enable;
    end else if (idx == `IDX_LOCKOUT_TRIM) begin
      v[`BIT_IDAC_DOUBLE] = s.idac_double;
      v[`BIT_FILT_LOW_BW] = s.filt_low_bw;
      v[`LSB_UVLO_LEVEL +: 2] = s.undervoltage_lockout_level;
    end else if (idx == `IDX_LOOP_FILTER_TRIM) begin
      v[`LSB_FILT_CAP +: 2] = s.filt_cap;
      v[1:0] = s.filt_res;
    end else if (idx == `IDX_EDGE_RATE_TRIM) begin
      v[`LSB_LOW_SLEW +: 2] = s.low_side_slew_setting;
      v[1:0] = s.high_side_slew_setting;
    end else if (idx == `IDX_TOP_CONFIG_FIVE) begin
      v[`BIT_DELAY_BYPASS] = s.delay_bypass;
      v[`BIT_HOLD_FREQ] = s.hold_frequency_on_reversal;
      v[`BIT_V2I_OFFSET] = s.voltage_current_offset_enable;
    end else if (idx == `IDX_FAULT_EVENT) begin
      v[`BIT_SAT_FLAG] = s.converter_saturation_flag;
    end else if (idx == `IDX_INT_STATE_TWO) begin
      v[`BIT_SAT_STATE] = s.converter_saturation_state;
    end else if (idx == `IDX_INT_MASK_TWO) begin
      v[`BIT_SAT_MASK] = s.converter_saturation_mask;
    end
    return v;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.ack = request;
    if (request && !wb_we_i) begin
      state_next.rdata = {24'h000000, read_byte(state_reg, index, snip_slot, in_snippet)};
    end

    if (wr_low) begin
      if (in_snippet) begin
        state_next.snippet[snip_slot] = wbyte;
      end else if (index == `IDX_PHASE_DELAY_LOW) begin
        state_next.delay_freeze = wbyte[`BIT_DELAY_FREEZE];
        // the field stores any code; keeping to 0x0 or 0x5 is up to software
        state_next.delay_shift = wbyte[2:0];
      end else if (index == `IDX_FREQ_TRACK_CTL) begin
        state_next.tracking_autoscale = wbyte[`BIT_TRACK_AUTOSCALE];
        state_next.tracking_force_enable = wbyte[`BIT_TRACK_FORCE];
      end else if (index == `IDX_LOCKOUT_TRIM) begin
        state_next.idac_double = wbyte[`BIT_IDAC_DOUBLE];
        state_next.filt_low_bw = wbyte[`BIT_FILT_LOW_BW];
        state_next.undervoltage_lockout_level = wbyte[`LSB_UVLO_LEVEL +: 2];
      end else if (index == `IDX_LOOP_FILTER_TRIM) begin
        state_next.filt_cap = wbyte[`LSB_FILT_CAP +: 2];
        state_next.filt_res = wbyte[1:0];
      end else if (index == `IDX_EDGE_RATE_TRIM) begin
        state_next.low_side_slew_setting = wbyte[`LSB_LOW_SLEW +: 2];
        state_next.high_side_slew_setting = wbyte[1:0];
      end else if (index == `IDX_TOP_CONFIG_FIVE) begin
        state_next.delay_bypass = wbyte[`BIT_DELAY_BYPASS];
        state_next.hold_frequency_on_reversal = wbyte[`BIT_HOLD_FREQ];
        state_next.voltage_current_offset_enable = wbyte[`BIT_V2I_OFFSET];
      end else if (index == `IDX_FAULT_EVENT) begin
        if (wbyte[`BIT_SAT_FLAG]) begin
          state_next.converter_saturation_flag = 1'b0;
        end
      end else if (index == `IDX_INT_MASK_TWO) begin
        state_next.converter_saturation_mask = wbyte[`BIT_SAT_MASK];
      end
    end

    // a saturation in the same cycle as the clearing write keeps the flag set
    if (converter_saturated) begin
      state_next.converter_saturation_flag = 1'b1;
    end
    state_next.converter_saturation_state = converter_saturated;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.delay_shift <= `RST_DELAY_SHIFT;
      state_reg.tracking_autoscale <= `RST_TRACK_AUTOSCALE;
      state_reg.undervoltage_lockout_level <= `RST_UVLO_LEVEL;
      state_reg.filt_cap <= `RST_FILT_CAP;
      state_reg.low_side_slew_setting <= `RST_SLEW;
      state_reg.high_side_slew_setting <= `RST_SLEW;
      state_reg.voltage_current_offset_enable <= `RST_V2I_OFFSET;
    end else if (clock_enable) begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
  assign snippet_read_data = (snippet_read_index < 7'd100) ? state_reg.snippet[snippet_read_index] : 8'h00;
  assign phase_delay_shift = state_reg.delay_shift;
  assign phase_delay_freeze = state_reg.delay_freeze;
  assign tracking_autoscale = state_reg.tracking_autoscale;
  assign loop_idac_double = state_reg.idac_double;
  assign loop_filter_low_bw = state_reg.filt_low_bw;
  assign loop_filter_cap = state_reg.filt_cap;
  assign loop_filter_res = state_reg.filt_res;
  assign delay_compare_bypass = state_reg.delay_bypass;
  // the request follows the sticky flag, not the momentary condition
  assign irq = state_reg.converter_saturation_flag & ~state_reg.converter_saturation_mask;

  tracking_force_guard u_guard (
    .force_enable(state_reg.tracking_force_enable),
    .tracking_error(tracking_error),
    .initial_guess(initial_guess),
    .force_tracking(force_tracking)
  );

  drive_setting_decode u_decode (
    .lockout_code(state_reg.undervoltage_lockout_level),
    .low_slew_code(state_reg.low_side_slew_setting),
    .high_slew_code(state_reg.high_side_slew_setting),
    .offset_enable(state_reg.voltage_current_offset_enable),
    .hold_on_reversal(state_reg.hold_frequency_on_reversal),
    .rapid_stop_active(rapid_stop_active),
    .negative_acceleration(negative_acceleration),
    .direct_override_negative(direct_override_negative),
    .lockout_threshold_dv(lockout_threshold_dv),
    .low_side_rate_mv_ns(low_side_rate_mv_ns),
    .high_side_rate_mv_ns(high_side_rate_mv_ns),
    .v2i_offset_mv(v2i_offset_mv),
    .pause_frequency_update(pause_frequency_update)
  );

endmodule // haptic_tuning_fault_register_bank

`default_nettype wire

// ---- tb/tuning_bank_asserts.sv ----
// port-level assertions for the tuning and fault register bank
`timescale 1ns/1ps
`default_nettype none

module tuning_bank_asserts
  import haptic_tuning_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clock_enable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [15:0] tracking_error,
  input wire logic [15:0] initial_guess,
  input wire logic force_tracking,
  input wire logic rapid_stop_active,
  input wire logic negative_acceleration,
  input wire logic direct_override_negative,
  input wire logic pause_frequency_update,
  input wire logic [7:0] lockout_threshold_dv,
  input wire logic [7:0] low_side_rate_mv_ns,
  input wire logic [7:0] v2i_offset_mv,
  input wire logic [6:0] snippet_read_index,
  input wire haptic_tuning_pkg::byte_t snippet_read_data,
  input wire logic irq
);
  // ****************************************************************
  // bus handshake and setting relations
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // a low clock enable freezes ack with everything else, so only an enabled cycle must drop it
  ack_single_pulse_a: assert property (wb_ack_o && clock_enable |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && clock_enable && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !wb_ack_o && !irq) else $error("reset leaves ack or irq");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read lanes not zero");
  irq_sticky_a: assert property (irq && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> irq) else $error("irq lost without write");
  force_cause_a: assert property (force_tracking |-> {tracking_error, 2'b00} > {2'b00, initial_guess})
    else $error("tracking forced below threshold");
  pause_cause_a: assert property (pause_frequency_update |->
    (rapid_stop_active || negative_acceleration || direct_override_negative)) else $error("pause without reversal");
  decode_range_a: assert property (lockout_threshold_dv >= 8'h1b && lockout_threshold_dv <= 8'h1e &&
    low_side_rate_mv_ns inside {8'h19, 8'h32, 8'h4b, 8'h64} && v2i_offset_mv inside {8'h00, 8'h32})
    else $error("decoded setting out of range");
  snippet_void_a: assert property (snippet_read_index > 7'h63 |-> snippet_read_data == 8'h00)
    else $error("snippet index beyond memory not zero");
endmodule // tuning_bank_asserts

bind haptic_tuning_fault_register_bank tuning_bank_asserts i_tuning_bank_asserts (.clock, .sys_rst, .clock_enable,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_dat_o, .tracking_error, .initial_guess, .force_tracking,
  .rapid_stop_active, .negative_acceleration, .direct_override_negative, .pause_frequency_update,
  .lockout_threshold_dv, .low_side_rate_mv_ns, .v2i_offset_mv, .snippet_read_index, .snippet_read_data, .irq);

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the tuning and fault register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import haptic_tuning_pkg::*;
  logic clock, sys_rst, clock_enable, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o, irq, converter_saturated;
  logic rapid_stop_active, negative_acceleration, direct_override_negative, force_tracking;
  logic pause_frequency_update, tracking_autoscale;
  logic phase_delay_freeze, loop_idac_double, loop_filter_low_bw, delay_compare_bypass;
  logic [1:0] loop_filter_cap, loop_filter_res;
  logic [9:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [15:0] tracking_error, initial_guess;
  logic [6:0] snippet_read_index;
  byte_t snippet_read_data;
  logic [2:0] phase_delay_shift;
  logic [7:0] lockout_threshold_dv, low_side_rate_mv_ns, high_side_rate_mv_ns, v2i_offset_mv, rd;
  int n_errors, total_checks, cycles;
  localparam logic [7:0] IDX [9] = '{8'h49, 8'h4c, 8'h5f, 8'h60, 8'h62, 8'h6e, 8'h81, 8'h82, 8'h83};
  localparam logic [7:0] RST [9] = '{8'h05, 8'h02, 8'h08, 8'h0c, 8'h0f, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK [9] = '{8'h87, 8'h03, 8'h78, 8'h0f, 8'h0f, 8'h07, 8'h00, 8'h00, 8'h80};

  haptic_tuning_fault_register_bank i_haptic_tuning_fault_register_bank (.*);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************************************************************
  // bus and compare helpers
  // ****************************************************************
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= s;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00, 4'hf);
    chk(rd, exp);
  endtask

  // one-cycle saturation event; irq is read after it has had a cycle to land
  task automatic pulse_sat();
    converter_saturated <= 1'b1;
    @(posedge clock);
    converter_saturated <= 1'b0;
    @(posedge clock);
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("[ERR] %0t ns: bench timed out", $time);
      give_verdict();
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    {n_errors, total_checks, cycles} = '0;
    {sys_rst, clock_enable} = 2'b11;
    {wb_we_i, wb_stb_i, wb_cyc_i, converter_saturated} = '0;
    {rapid_stop_active, negative_acceleration, direct_override_negative} = '0;
    {wb_adr_i, wb_dat_i, wb_sel_i, tracking_error, initial_guess, snippet_read_index} = '0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk(8'(phase_delay_shift), 8'h05);
    chk(8'(tracking_autoscale), 8'h01);
    chk(lockout_threshold_dv, 8'h1c);
    chk(high_side_rate_mv_ns, 8'h64);
    chk(v2i_offset_mv, 8'h32);
    chk({phase_delay_freeze, loop_idac_double, loop_filter_low_bw, delay_compare_bypass, loop_filter_cap,
      loop_filter_res}, 8'h0c);
    foreach (IDX[i]) rdchk(IDX[i], RST[i]);
    rdchk(8'h84, 8'h00);
    rdchk(8'he7, 8'h00);
    // all-ones writes show which bits hold and that the status place ignores writes
    foreach (IDX[i]) begin
      wb(1'b1, IDX[i], 8'hff, 4'hf);
      rdchk(IDX[i], MSK[i]);
    end
    chk({phase_delay_freeze, loop_idac_double, loop_filter_low_bw, delay_compare_bypass, loop_filter_cap,
      loop_filter_res}, 8'hff);
    wb(1'b1, 8'h5f, 8'h00, 4'he);
    rdchk(8'h5f, 8'h78);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, 8'h5f, 8'(c << 3), 4'h1);
      wb(1'b1, 8'h62, 8'(c * 5), 4'h1);
      chk(lockout_threshold_dv, 8'(27 + c));
      chk(low_side_rate_mv_ns, 8'(25 * (c + 1)));
      chk(high_side_rate_mv_ns, 8'(25 * (c + 1)));
    end
    wb(1'b1, 8'h6e, 8'h00, 4'h1);
    chk(v2i_offset_mv, 8'h00);
    wb(1'b1, 8'h49, 8'h00, 4'h1);
    chk(8'(phase_delay_shift), 8'h00);
    wb(1'b1, 8'h49, 8'h05, 4'h1);
    chk(8'(phase_delay_shift), 8'h05);
    wb(1'b1, 8'h4c, 8'h00, 4'h1);
    chk(8'(tracking_autoscale), 8'h00);
    // error of exactly a quarter must not force tracking
    initial_guess <= 16'd400;
    tracking_error <= 16'd100;
    wb(1'b1, 8'h4c, 8'h01, 4'h1);
    chk(8'(force_tracking), 8'h00);
    tracking_error <= 16'd101;
    @(posedge clock);
    chk(8'(force_tracking), 8'h01);
    wb(1'b1, 8'h4c, 8'h00, 4'h1);
    chk(8'(force_tracking), 8'h00);
    wb(1'b1, 8'h6e, 8'h02, 4'h1);
    for (int i = 0; i < 4; i++) begin
      {rapid_stop_active, negative_acceleration, direct_override_negative} <= 3'(4'h1 << i);
      @(posedge clock);
      chk(8'(pause_frequency_update), 8'(i < 3));
    end
    {rapid_stop_active, negative_acceleration, direct_override_negative} <= 3'h7;
    wb(1'b1, 8'h6e, 8'h00, 4'h1);
    chk(8'(pause_frequency_update), 8'h00);
    wb(1'b1, 8'h83, 8'h00, 4'h1);
    pulse_sat();
    chk(8'(irq), 8'h01);
    wb(1'b1, 8'h81, 8'h00, 4'h1);
    rdchk(8'h81, 8'h04);
    converter_saturated <= 1'b1;
    rdchk(8'h82, 8'h80);
    converter_saturated <= 1'b0;
    rdchk(8'h82, 8'h00);
    wb(1'b1, 8'h81, 8'h04, 4'h1);
    rdchk(8'h81, 8'h00);
    chk(8'(irq), 8'h00);
    wb(1'b1, 8'h83, 8'h80, 4'h1);
    pulse_sat();
    chk(8'(irq), 8'h00);
    rdchk(8'h81, 8'h04);
    wb(1'b1, 8'h83, 8'h00, 4'h1);
    chk(8'(irq), 8'h01);
    wb(1'b1, 8'h81, 8'h04, 4'h1);
    chk(8'(irq), 8'h00);
    // a saturation while the clock enable is low must leave no trace
    clock_enable <= 1'b0;
    pulse_sat();
    chk(8'(irq), 8'h00);
    clock_enable <= 1'b1;
    rdchk(8'h81, 8'h00);
    wb(1'b1, 8'h84, 8'ha5, 4'h1);
    wb(1'b1, 8'he7, 8'h5a, 4'h1);
    wb(1'b1, 8'hb0, 8'h3c, 4'h1);
    wb(1'b1, 8'hf0, 8'hff, 4'h1);
    rdchk(8'h84, 8'ha5);
    rdchk(8'he7, 8'h5a);
    rdchk(8'hb0, 8'h3c);
    rdchk(8'hf0, 8'h00);
    snippet_read_index <= 7'd99;
    @(posedge clock);
    chk(snippet_read_data, 8'h5a);
    snippet_read_index <= 7'd100;
    @(posedge clock);
    chk(snippet_read_data, 8'h00);
    // a reset in mid-run must clear written snippet bytes and restore defaults
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rdchk(8'h84, 8'h00);
    rdchk(8'h4c, 8'h02);
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
